// [src/prom_prog_host.sv]
// Purpose: byte-wide program/verify sequencer driving the prom pins
// Assumes: CORE_CLK 25 MHz, one byte per request, RESETN async low
// Notes:   data pins are three signals; enable low means we drive
`timescale 1ns/1ps

// Behaviour
// - pin pattern picks write, verify or inhibit; data floats when inhibited
// - one byte per program cycle, never page programming
// - only program addresses from lowest location through usable limit
// - unused addresses stay all-ones, never programmed to anything else
// - every byte write followed by verify read of same address
// - overwrite pulse held between its minimum and maximum limits
// - addresses beyond usable range are given the all-ones byte
module prom_prog_host (
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic        REQ_VALID,
  input  wire logic [16:0] REQ_ADDR,
  input  wire logic [7:0]  REQ_DATA,
  input  wire logic [7:0]  DATA_PINS_IN,
  output logic             REQ_READY,
  output logic             DONE_PULSE,
  output logic             DONE_FAIL,
  output logic [7:0]       DONE_RETRIES,
  output logic [16:0]      ADDR_PINS,
  output logic [7:0]       DATA_PINS_OUT,
  output logic             DATA_PINS_OE_N,
  output logic             CHIP_ENABLE_N,
  output logic             OUTPUT_ENABLE_N,
  output logic             PROGRAM_STROBE_N
);

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser on the data pins
  logic [7:0] data_meta;
  logic [7:0] data_sync;

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      data_meta <= 8'h00;
      data_sync <= 8'h00;
    end
    else
    begin
      data_meta <= DATA_PINS_IN;
      data_sync <= data_meta;
    end
  end

  localparam int TMR_W_L = prom_prog_pkg::TMR_W;
  function automatic logic [TMR_W_L-1:0] cyc(input int unsigned n);
    cyc = TMR_W_L'(n - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  prom_prog_pkg::prog_state_t state, next_state;
  logic [TMR_W_L-1:0] tmr, next_tmr;
  logic [16:0] addr, next_addr;
  logic [7:0] data, next_data;
  logic [7:0] tries, next_tries;
  prom_prog_pkg::ctrl_pins_t ctrl, next_ctrl;
  logic drive_n, next_drive_n;
  logic ready, next_ready;
  logic done, next_done;
  logic fail, next_fail;
  logic skip, beyond;

  // no write outside the usable range: the byte is only checked
  assign beyond = REQ_ADDR > prom_prog_pkg::ADDR_LAST_USABLE;
  assign skip = beyond || (REQ_DATA == prom_prog_pkg::ERASED_BYTE);

  always_comb
  begin
    next_state = state;
    next_tmr = (tmr != prom_prog_pkg::TMR_ZERO) ? tmr - 1'b1 : tmr;
    next_addr = addr;
    next_data = data;
    next_tries = tries;
    next_ctrl = ctrl;
    next_drive_n = drive_n;
    next_ready = 1'b0;
    next_done = 1'b0;
    next_fail = fail;
    case (state)
      prom_prog_pkg::ST_IDLE:
      begin
        next_ready = 1'b1;
        if (REQ_VALID && ready)
        begin
          // one byte per request, no page mode exists here
          next_ready = 1'b0;
          next_addr = REQ_ADDR;
          next_data = beyond ? prom_prog_pkg::ERASED_BYTE : REQ_DATA;
          next_tries = 8'h00;
          next_fail = 1'b0;
          next_ctrl = prom_prog_pkg::CTRL_ADDR_ONLY;
          next_tmr = cyc(prom_prog_pkg::SETUP_CYC);
          next_drive_n = skip;
          next_state = skip ? prom_prog_pkg::ST_VSETUP
                            : prom_prog_pkg::ST_SETUP;
        end
      end
      prom_prog_pkg::ST_SETUP:
        if (tmr == prom_prog_pkg::TMR_ZERO)
        begin
          next_ctrl = prom_prog_pkg::CTRL_WRITE;
          next_tmr = cyc(prom_prog_pkg::PULSE_CYC);
          next_tries = tries + 8'h01;
          next_state = prom_prog_pkg::ST_PULSE;
        end
      prom_prog_pkg::ST_PULSE:
        if (tmr == prom_prog_pkg::TMR_ZERO)
        begin
          next_ctrl = prom_prog_pkg::CTRL_ADDR_ONLY;
          next_tmr = cyc(prom_prog_pkg::HOLD_CYC);
          next_state = prom_prog_pkg::ST_HOLD;
        end
      prom_prog_pkg::ST_HOLD:
        if (tmr == prom_prog_pkg::TMR_ZERO)
        begin
          // release the bus before the device may drive it
          next_drive_n = 1'b1;
          next_tmr = cyc(prom_prog_pkg::SETUP_CYC);
          next_state = prom_prog_pkg::ST_VSETUP;
        end
      prom_prog_pkg::ST_VSETUP:
        if (tmr == prom_prog_pkg::TMR_ZERO)
        begin
          next_ctrl = prom_prog_pkg::CTRL_VERIFY;
          next_tmr = cyc(prom_prog_pkg::OUT_DELAY_CYC + 2);
          next_state = prom_prog_pkg::ST_VREAD;
        end
      prom_prog_pkg::ST_VREAD:
        if (tmr == prom_prog_pkg::TMR_ZERO)
        begin
          next_ctrl = prom_prog_pkg::CTRL_ADDR_ONLY;
          next_tmr = cyc(prom_prog_pkg::DISABLE_CYC);
          if (data_sync == data && tries != 8'h00)
          begin
            next_drive_n = 1'b0;
            next_state = prom_prog_pkg::ST_VEND;
          end
          else if (data_sync == data)
          begin
            next_state = prom_prog_pkg::ST_DONE;
          end
          else if (tries == 8'h00 ||
                   tries >= 8'(prom_prog_pkg::RETRY_MAX))
          begin
            next_fail = 1'b1;
            next_state = prom_prog_pkg::ST_DONE;
          end
          else
          begin
            next_drive_n = 1'b0;
            next_tmr = cyc(prom_prog_pkg::SETUP_CYC);
            next_state = prom_prog_pkg::ST_SETUP;
          end
        end
      prom_prog_pkg::ST_VEND:
        if (tmr == prom_prog_pkg::TMR_ZERO)
        begin
          // overwrite pulse sized at its minimum limit, well under max
          next_ctrl = prom_prog_pkg::CTRL_WRITE;
          next_tmr = cyc(prom_prog_pkg::OVERWRITE_MIN_CYC);
          next_state = prom_prog_pkg::ST_OVER;
        end
      prom_prog_pkg::ST_OVER:
        if (tmr == prom_prog_pkg::TMR_ZERO)
        begin
          next_ctrl = prom_prog_pkg::CTRL_ADDR_ONLY;
          next_tmr = cyc(prom_prog_pkg::HOLD_CYC);
          next_state = prom_prog_pkg::ST_OHOLD;
        end
      prom_prog_pkg::ST_OHOLD:
        if (tmr == prom_prog_pkg::TMR_ZERO)
        begin
          next_drive_n = 1'b1;
          next_state = prom_prog_pkg::ST_DONE;
        end
      prom_prog_pkg::ST_DONE:
      begin
        next_ctrl = prom_prog_pkg::CTRL_IDLE;
        next_drive_n = 1'b1;
        next_done = 1'b1;
        next_state = prom_prog_pkg::ST_IDLE;
      end
      default:
        next_state = prom_prog_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state <= prom_prog_pkg::ST_IDLE;
      tmr <= prom_prog_pkg::TMR_ZERO;
      addr <= 17'h0_0000;
      data <= 8'h00;
      tries <= 8'h00;
      ctrl <= prom_prog_pkg::CTRL_IDLE;
      drive_n <= 1'b1;
      ready <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tmr <= next_tmr;
      addr <= next_addr;
      data <= next_data;
      tries <= next_tries;
      ctrl <= next_ctrl;
      drive_n <= next_drive_n;
      ready <= next_ready;
      done <= next_done;
      fail <= next_fail;
    end
  end

  assign REQ_READY = ready;
  assign DONE_PULSE = done;
  assign DONE_FAIL = fail;
  assign DONE_RETRIES = tries;
  assign ADDR_PINS = addr;
  assign DATA_PINS_OUT = data;
  assign DATA_PINS_OE_N = drive_n;
  assign CHIP_ENABLE_N = ctrl.chip_enable_n;
  assign OUTPUT_ENABLE_N = ctrl.output_enable_n;
  assign PROGRAM_STROBE_N = ctrl.program_strobe_n;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_no_drive_in_verify;
    @(posedge CORE_CLK) disable iff (!RESETN)
      !OUTPUT_ENABLE_N |-> DATA_PINS_OE_N && PROGRAM_STROBE_N;
  endproperty
  a_no_drive_in_verify: assert property (p_no_drive_in_verify)
    else $error("host drives data while verify selected");

  property p_write_drives;
    @(posedge CORE_CLK) disable iff (!RESETN)
      !PROGRAM_STROBE_N |-> !DATA_PINS_OE_N && OUTPUT_ENABLE_N;
  endproperty
  a_write_drives: assert property (p_write_drives)
    else $error("strobe low without data driven");

  property p_range;
    @(posedge CORE_CLK) disable iff (!RESETN)
      !PROGRAM_STROBE_N |-> ADDR_PINS <= prom_prog_pkg::ADDR_LAST_USABLE;
  endproperty
  a_range: assert property (p_range)
    else $error("strobe on address above usable range");

  property p_no_ff_write;
    @(posedge CORE_CLK) disable iff (!RESETN)
      !PROGRAM_STROBE_N |-> DATA_PINS_OUT != prom_prog_pkg::ERASED_BYTE;
  endproperty
  a_no_ff_write: assert property (p_no_ff_write)
    else $error("all-ones byte programmed");

  property p_verify_follows;
    @(posedge CORE_CLK) disable iff (!RESETN)
      $rose(PROGRAM_STROBE_N) && state == prom_prog_pkg::ST_HOLD
        |-> ##[1:200] !OUTPUT_ENABLE_N;
  endproperty
  a_verify_follows: assert property (p_verify_follows)
    else $error("no verify after write");

  property p_over_len;
    @(posedge CORE_CLK) disable iff (!RESETN)
      $rose(state == prom_prog_pkg::ST_OVER) |-> !PROGRAM_STROBE_N &&
        tmr == TMR_W_L'(prom_prog_pkg::OVERWRITE_MIN_CYC - 1);
  endproperty
  a_over_len: assert property (p_over_len)
    else $error("overwrite pulse length wrong");

  property p_retry_bound;
    @(posedge CORE_CLK) disable iff (!RESETN)
      tries <= 8'(prom_prog_pkg::RETRY_MAX);
  endproperty
  a_retry_bound: assert property (p_retry_bound)
    else $error("retry count exceeded");

  property p_one_byte;
    @(posedge CORE_CLK) disable iff (!RESETN)
      !PROGRAM_STROBE_N |-> $stable(ADDR_PINS);
  endproperty
  a_one_byte: assert property (p_one_byte)
    else $error("address moved during program pulse");

endmodule // prom_prog_host

// [src/prom_prog_pkg.sv]
// Purpose: constants and types for the byte-wide prom programmer
// Assumes: 25 MHz core clock
// Notes:   times kept in their own unit, cycle counts derived
package prom_prog_pkg;

  localparam int unsigned CLK_NS = 40;

  // address range and fill value
  localparam logic [16:0] ADDR_FIRST = 17'h0_0000;
  localparam logic [16:0] ADDR_LAST_USABLE = 17'h0_EF7F;
  localparam logic [16:0] ADDR_FIRST_UNUSED = 17'h0_EF80;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // times
  localparam int unsigned SETUP_US = 2;
  localparam int unsigned HOLD_US = 2;
  localparam int unsigned PULSE_US = 200;
  localparam int unsigned OVERWRITE_MIN_US = 190;
  localparam int unsigned OVERWRITE_MAX_US = 5250;
  localparam int unsigned OUT_DELAY_NS = 150;
  localparam int unsigned DISABLE_NS = 130;

  // cycle counts: least times round up
  localparam int unsigned SETUP_CYC = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOLD_CYC = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PULSE_CYC = (PULSE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OUT_DELAY_CYC =
    (OUT_DELAY_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int unsigned DISABLE_CYC = (DISABLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OVERWRITE_MIN_CYC =
    (OVERWRITE_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OVERWRITE_MAX_CYC =
    (OVERWRITE_MAX_US * 1000) / CLK_NS;
  localparam int unsigned RETRY_MAX = 25;

  localparam int unsigned TMR_W = 18;
  localparam logic [TMR_W-1:0] TMR_ZERO = 18'h0_0000;

  typedef struct packed {
    logic        chip_enable_n;
    logic        output_enable_n;
    logic        program_strobe_n;
  } ctrl_pins_t;

  localparam ctrl_pins_t CTRL_IDLE = 3'h7;
  localparam ctrl_pins_t CTRL_WRITE = 3'h2;
  localparam ctrl_pins_t CTRL_VERIFY = 3'h1;
  localparam ctrl_pins_t CTRL_ADDR_ONLY = 3'h3;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_VSETUP, ST_VREAD,
    ST_VEND, ST_OVER, ST_OHOLD, ST_DONE
  } prog_state_t;

endpackage

// [bench/prom_device_model.sv]
// Purpose: behavioural model of the prom in program/verify mode
// Assumes: pins driven by the host; the device itself has no clock
// Notes:   one slow cell ignores its first pulse so that a retry shows
`timescale 1ns/1ps
module prom_device_model (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        strobe_n,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  data_in,
  input  wire logic [16:0] slow_addr,
  output logic [7:0]       data_out,
  output logic             data_drive
);
  logic [7:0]  mem [0:131071];
  logic [16:0] last_wr_addr;
  int          pulses, bad_addr, last_width, slow_hits, vcount;
  realtime     t_low;
  initial
  begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
    {pulses, bad_addr, last_width, slow_hits, vcount} = '0;
    last_wr_addr = 17'h1_FFFF;
  end
  ////////////////////////////////////////////////////////////////////////
  // only ce low, oe low, strobe high drives; every other pattern floats
  assign data_drive = !ce_n && !oe_n && strobe_n;
  assign data_out   = mem[addr];
  always @(negedge strobe_n) t_low = $realtime;
  // write only with ce low and oe high
  always @(posedge strobe_n)
  begin
    if (!ce_n && oe_n)
    begin
      pulses++;
      last_width = int'(($realtime - t_low) / 40.0);
      if (addr > 17'h0_EF7F) bad_addr++;
      if (addr == slow_addr && slow_hits == 0) slow_hits = 1;
      else mem[addr] = mem[addr] & data_in;
      last_wr_addr = addr;
    end
  end
  always @(negedge oe_n)
    if (!ce_n && strobe_n && addr == last_wr_addr) vcount++;
endmodule // prom_device_model

// [bench/tb.sv]
// Purpose: self-checking bench for the prom program/verify sequencer
// Assumes: 25 MHz clock, inputs changed on the falling edge
// Notes:   full-length pulse counts, so each programmed byte costs about 10k cycles, 5k more per retry
`timescale 1ns/1ps
module tb;
  logic        core_clk, resetn, req_valid, req_ready, done_pulse, done_fail;
  logic        oe_n, ce_n, out_en_n, strobe_n, dev_drive, f;
  logic [16:0] req_addr, addr_pins, slow_addr;
  logic [7:0]  req_data, done_retries, data_out, dev_q, data_bus, rt;
  int          err_count, comparisons, clash, cyc, p0, v0;
  // undriven bus flips every cycle: no pull on these lines
  assign data_bus = dev_drive ? dev_q : !oe_n ? data_out :
                    (8'hA5 ^ {8{cyc[0]}});
  prom_prog_host dut (.CORE_CLK(core_clk), .RESETN(resetn),
    .REQ_VALID(req_valid), .REQ_ADDR(req_addr), .REQ_DATA(req_data),
    .DATA_PINS_IN(data_bus), .REQ_READY(req_ready),
    .DONE_PULSE(done_pulse), .DONE_FAIL(done_fail),
    .DONE_RETRIES(done_retries), .ADDR_PINS(addr_pins),
    .DATA_PINS_OUT(data_out), .DATA_PINS_OE_N(oe_n),
    .CHIP_ENABLE_N(ce_n), .OUTPUT_ENABLE_N(out_en_n),
    .PROGRAM_STROBE_N(strobe_n));
  prom_device_model dev (.ce_n(ce_n), .oe_n(out_en_n), .strobe_n(strobe_n),
    .addr(addr_pins), .data_in(data_bus), .slow_addr(slow_addr),
    .data_out(dev_q), .data_drive(dev_drive));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (dev_drive && oe_n === 1'b0) clash <= clash + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one request, held until taken, then wait for the end-of-byte pulse
  task automatic do_byte(input logic [16:0] a, input logic [7:0] d);
    int n;
    begin
      p0 = dev.pulses;
      v0 = dev.vcount;
      n = 0;
      @(negedge core_clk);
      req_addr = a;
      req_data = d;
      req_valid = 1'b1;
      // taken at the rising edge that sees ready high; drop valid after it
      do @(posedge core_clk); while (req_ready !== 1'b1 && ++n < 100);
      @(negedge core_clk);
      req_valid = 1'b0;
      n = 0;
      do begin @(posedge core_clk); #1; n++; end
      while (done_pulse !== 1'b1 && n < 20000);
      check(done_pulse, 1'b1);
      f = done_fail;
      rt = done_retries;
      @(negedge core_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_plain();
    do_byte(17'h0_0000, 8'h5A);
    check(f, 1'b0);
    check(dev.mem[0], 8'h5A);
    check(dev.pulses - p0, 2);
    check(dev.vcount - v0, 1);
    check(rt, 8'h01);
    check(32'(dev.last_width >= prom_prog_pkg::OVERWRITE_MIN_CYC &&
      dev.last_width <= prom_prog_pkg::OVERWRITE_MAX_CYC), 1);
  endtask
  task automatic t_slow_last();
    slow_addr = prom_prog_pkg::ADDR_LAST_USABLE;
    do_byte(prom_prog_pkg::ADDR_LAST_USABLE, 8'h00);
    check(f, 1'b0);
    check(dev.mem[17'h0_EF7F], 8'h00);
    check(dev.pulses - p0, 3);
    check(dev.vcount - v0, 2);
    check(rt, 8'h02);
  endtask
  task automatic t_beyond();
    do_byte(17'h0_EF80, 8'hFF);
    check(dev.pulses - p0, 0);
    check(f, 1'b0);
    check(rt, 8'h00);
    do_byte(17'h1_FFFF, 8'h3C);
    check(dev.pulses - p0, 0);
    check(f, 1'b0);
    check(dev.mem[17'h1_FFFF], 8'hFF);
  endtask
  task automatic t_unused_ff();
    do_byte(17'h0_0100, 8'hFF);
    check(dev.pulses - p0, 0);
    check(dev.mem[17'h0_0100], 8'hFF);
    check(f, 1'b0);
    dev.mem[17'h1_0000] = 8'h00;
    do_byte(17'h1_0000, 8'hFF);
    check(f, 1'b1);
    check(dev.pulses - p0, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {err_count, comparisons, clash, cyc} = '0;
    {resetn, req_valid, req_addr, req_data} = '0;
    slow_addr = 17'h1_FFFF;
    repeat (3) @(negedge core_clk);
    check({ce_n, out_en_n, strobe_n, oe_n, req_ready}, 5'h1E);
    resetn = 1'b1;
    repeat (2) @(negedge core_clk);
    t_plain();
    t_slow_last();
    t_beyond();
    t_unused_ff();
    check(dev.bad_addr, 0);
    check(clash, 0);
    print_verdict();
  end
  initial
  begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
endmodule // tb
